//--- rtl/acc_defines.svh
// Register offsets, field positions and reset values of the comparator control block.
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_OFF_STATUS_CTRL 8'h50
`define ACC_OFF_CONV_CTRL_B 8'h7B
`define ACC_OFF_PIN_DISABLE 8'h7F
`define ACC_OFF_IRQ_STATUS 8'h80
`define ACC_OFF_IRQ_MASK 8'h84
`define ACC_BIT_DISABLE 7
`define ACC_BIT_BANDGAP 6
`define ACC_BIT_RESULT 5
`define ACC_BIT_FLAG 4
`define ACC_BIT_IRQ_EN 3
`define ACC_BIT_CAPTURE 2
`define ACC_BIT_MODE_HI 1
`define ACC_BIT_MODE_LO 0
`define ACC_BIT_MUX_EN 6
`define ACC_BIT_NEG_PIN_DIS 1
`define ACC_BIT_POS_PIN_DIS 0
`define ACC_CONV_CTRL_B_MASK 8'h47
`define ACC_PIN_DISABLE_MASK 8'h03
`define ACC_RESET_BYTE 8'h00
`define ACC_RESET_MASK 2'h0
`endif

//--- rtl/acc_pkg.sv
// Types shared by the comparator control block.
package acc_pkg;
   typedef enum logic [1:0] {
      ACC_MODE_TOGGLE = 2'h0,
      ACC_MODE_RSVD = 2'h1,
      ACC_MODE_FALL = 2'h2,
      ACC_MODE_RISE = 2'h3
   } acc_mode_t;
   typedef enum logic [2:0] {
      ACC_BUS_IDLE = 3'h1,
      ACC_BUS_ACK = 3'h2,
      ACC_BUS_DONE = 3'h4
   } acc_bus_t;
endpackage

//--- rtl/acc_sync.sv
// Two flip-flop synchroniser for the raw comparator output.
`timescale 1ns/100ps
module acc_sync
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic async_i,
   output logic sync_o
);
   typedef struct packed
   {
      logic meta;
      logic sync;
   } acc_sync_state_t;
   acc_sync_state_t state_ff;
   acc_sync_state_t nxt_state;

   // The first stage feeds only the second stage.
   always_comb
   begin
      nxt_state.meta = async_i;
      nxt_state.sync = state_ff.meta;
   end

   // Both stages clear on reset.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign sync_o = state_ff.sync;
endmodule // acc_sync

//--- rtl/acc_ctrl.sv
// Analog comparator control with a classic Wishbone register slave.
// Operation
// - Result is high when positive input exceeds negative input.
// - Mux enable and converter off choose channel 0..7 as negative input.
// - Bandgap select feeds bandgap to positive input, else positive pin.
// - Raw output is synchronised before reading, one to two cycles late.
// - Flag sets on the edge event chosen by the mode bits.
// - Flag clears on vector acknowledge or on writing one.
// - Request asserts only with flag, enable and global enable.
// - Mode 00 toggle, 10 falling, 11 rising, 01 reserved.
// - Disable bit powers the comparator off; zero powers it on.
// - Capture routing bit connects the result to the timer capture input.
// - Pin disable bits stop input buffers and force readback to zero.
// - Unused pin disable bits read as zero.
`timescale 1ns/100ps
`include "acc_defines.svh"
module acc_ctrl
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic comparator_raw_i,
   output logic comparator_power_down_o,
   output logic positive_bandgap_sel_o,
   output logic negative_from_mux_o,
   output logic [2:0] negative_channel_o,
   input wire logic converter_enable_i,
   input wire logic [2:0] channel_select_i,
   input wire logic global_irq_enable_i,
   input wire logic irq_vector_ack_i,
   output logic comparator_irq_o,
   output logic capture_trigger_o,
   output logic capture_routing_enable_o,
   output logic [2:0] converter_trigger_select_o,
   output logic negative_pin_buffer_off_o,
   output logic positive_pin_buffer_off_o,
   input wire logic negative_pin_digital_i,
   input wire logic positive_pin_digital_i,
   output logic negative_pin_readback_o,
   output logic positive_pin_readback_o,
   output logic event_irq_o
);
   import acc_pkg::*;

   typedef struct packed
   {
      acc_bus_t bus;
      logic [31:0] rdata;
      logic [7:0] status_ctrl;
      logic [7:0] conv_ctrl_b;
      logic [1:0] pin_disable;
      logic [1:0] evt_status;
      logic [1:0] evt_mask;
      logic result_prev;
      logic readback_neg;
      logic readback_pos;
   } acc_state_t;

   acc_state_t state_ff;
   acc_state_t nxt_state;
   logic result_sync;
   logic [1:0] pin_digital;
   logic [1:0] pin_sync;
   logic edge_rise;
   logic edge_fall;
   logic mode_event;
   logic access;
   logic wr_en;
   logic [7:0] wbyte;
   logic [7:0] rd_byte;
   acc_mode_t mode;

   // Raw comparator output enters the clock domain here.
   acc_sync u_sync
   (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .async_i(comparator_raw_i),
      .sync_o(result_sync)
   );

   // Each pin level passes its own two flip-flops before the readback logic sees it.
   assign pin_digital = {negative_pin_digital_i, positive_pin_digital_i};
   generate
      for (genvar pin = 0; pin < 2; pin++)
      begin : g_pin_sync
         acc_sync u_pin_sync
         (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .async_i(pin_digital[pin]),
            .sync_o(pin_sync[pin])
         );
      end
   endgenerate

   // Edge detection on the synchronised result and mode decode.
   assign mode = acc_mode_t'(state_ff.status_ctrl[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO]);
   assign edge_rise = result_sync & ~state_ff.result_prev;
   assign edge_fall = ~result_sync & state_ff.result_prev;
   always_comb
   begin
      case (mode)
         ACC_MODE_TOGGLE: mode_event = edge_rise | edge_fall;
         ACC_MODE_FALL: mode_event = edge_fall;
         ACC_MODE_RISE: mode_event = edge_rise;
         default: mode_event = 1'b0;
      endcase
   end

   // Bus decode; the lane for the addressed byte is byte lane 0.
   assign access = wb_cyc_i & wb_stb_i & (state_ff.bus == ACC_BUS_IDLE);
   assign wr_en = access & wb_we_i & wb_sel_i[0];
   assign wbyte = wb_dat_i[7:0];

   // Read multiplexer; unmapped addresses read as zero.
   always_comb
   begin
      case (wb_adr_i)
         `ACC_OFF_STATUS_CTRL:
         begin
            rd_byte = state_ff.status_ctrl;
            rd_byte[`ACC_BIT_RESULT] = result_sync;
         end
         `ACC_OFF_CONV_CTRL_B: rd_byte = state_ff.conv_ctrl_b & `ACC_CONV_CTRL_B_MASK;
         `ACC_OFF_PIN_DISABLE: rd_byte = {6'h00, state_ff.pin_disable};
         `ACC_OFF_IRQ_STATUS: rd_byte = {6'h00, state_ff.evt_status};
         `ACC_OFF_IRQ_MASK: rd_byte = {6'h00, state_ff.evt_mask};
         default: rd_byte = 8'h00;
      endcase
   end

   // Next state of the bus, registers and flags.
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.result_prev = result_sync;
      nxt_state.readback_neg = pin_sync[`ACC_BIT_NEG_PIN_DIS]
         & ~state_ff.pin_disable[`ACC_BIT_NEG_PIN_DIS];
      nxt_state.readback_pos = pin_sync[`ACC_BIT_POS_PIN_DIS]
         & ~state_ff.pin_disable[`ACC_BIT_POS_PIN_DIS];
      case (state_ff.bus)
         ACC_BUS_IDLE:
         begin
            if (access)
            begin
               nxt_state.bus = ACC_BUS_ACK;
               nxt_state.rdata = {24'h000000, rd_byte};
            end
         end
         ACC_BUS_ACK: nxt_state.bus = ACC_BUS_DONE;
         ACC_BUS_DONE: nxt_state.bus = ACC_BUS_IDLE;
         default: nxt_state.bus = ACC_BUS_IDLE;
      endcase
      if (wr_en)
      begin
         case (wb_adr_i)
            `ACC_OFF_STATUS_CTRL:
            begin
               nxt_state.status_ctrl[`ACC_BIT_DISABLE] = wbyte[`ACC_BIT_DISABLE];
               nxt_state.status_ctrl[`ACC_BIT_BANDGAP] = wbyte[`ACC_BIT_BANDGAP];
               nxt_state.status_ctrl[3:0] = wbyte[3:0];
               if (wbyte[`ACC_BIT_FLAG])
                  nxt_state.status_ctrl[`ACC_BIT_FLAG] = 1'b0;
            end
            `ACC_OFF_CONV_CTRL_B: nxt_state.conv_ctrl_b = wbyte & `ACC_CONV_CTRL_B_MASK;
            `ACC_OFF_PIN_DISABLE: nxt_state.pin_disable = wbyte[1:0];
            `ACC_OFF_IRQ_STATUS: nxt_state.evt_status = state_ff.evt_status & ~wbyte[1:0];
            `ACC_OFF_IRQ_MASK: nxt_state.evt_mask = wbyte[1:0];
            default: nxt_state.evt_mask = state_ff.evt_mask;
         endcase
      end
      if (irq_vector_ack_i)
         nxt_state.status_ctrl[`ACC_BIT_FLAG] = 1'b0;
      // A new event wins over a clear in the same cycle.
      if (mode_event)
         nxt_state.status_ctrl[`ACC_BIT_FLAG] = 1'b1;
      nxt_state.status_ctrl[`ACC_BIT_RESULT] = 1'b0;
      if (edge_rise)
         nxt_state.evt_status[0] = 1'b1;
      if (edge_fall)
         nxt_state.evt_status[1] = 1'b1;
   end

   // State register.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= '0;
         state_ff.bus <= ACC_BUS_IDLE;
      end
      else
         state_ff <= nxt_state;
   end

   // Bus answers one cycle after the request is taken.
   assign wb_ack_o = (state_ff.bus == ACC_BUS_ACK);
   assign wb_dat_o = state_ff.rdata;

   // Analog steering outputs.
   assign comparator_power_down_o = state_ff.status_ctrl[`ACC_BIT_DISABLE];
   assign positive_bandgap_sel_o = state_ff.status_ctrl[`ACC_BIT_BANDGAP];
   assign negative_from_mux_o = state_ff.conv_ctrl_b[`ACC_BIT_MUX_EN] & ~converter_enable_i;
   assign negative_channel_o = channel_select_i;
   assign converter_trigger_select_o = state_ff.conv_ctrl_b[2:0];

   // Interrupt requests, capture routing and pin buffer outputs.
   assign comparator_irq_o = state_ff.status_ctrl[`ACC_BIT_FLAG]
      & state_ff.status_ctrl[`ACC_BIT_IRQ_EN] & global_irq_enable_i;
   assign capture_routing_enable_o = state_ff.status_ctrl[`ACC_BIT_CAPTURE];
   assign capture_trigger_o = result_sync & state_ff.status_ctrl[`ACC_BIT_CAPTURE];
   assign negative_pin_buffer_off_o = state_ff.pin_disable[`ACC_BIT_NEG_PIN_DIS];
   assign positive_pin_buffer_off_o = state_ff.pin_disable[`ACC_BIT_POS_PIN_DIS];
   assign negative_pin_readback_o = state_ff.readback_neg;
   assign positive_pin_readback_o = state_ff.readback_pos;
   assign event_irq_o = |(state_ff.evt_status & state_ff.evt_mask);

   // Flag follows a rising edge in rising mode within one cycle.
   rise_sets_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode == ACC_MODE_RISE && edge_rise) |=> state_ff.status_ctrl[`ACC_BIT_FLAG])
      else $error("rising edge did not set flag");
   // Reserved mode never sets the flag by itself.
   reserved_mode_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode == ACC_MODE_RSVD && !state_ff.status_ctrl[`ACC_BIT_FLAG] && !wr_en)
      |=> !state_ff.status_ctrl[`ACC_BIT_FLAG])
      else $error("reserved mode set flag");
   // Vector acknowledge clears the flag unless a new event arrives.
   vector_clears_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (irq_vector_ack_i && !mode_event) |=> !state_ff.status_ctrl[`ACC_BIT_FLAG])
      else $error("vector did not clear flag");
   // Request needs flag, enable and global enable.
   irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      comparator_irq_o |-> (state_ff.status_ctrl[`ACC_BIT_FLAG] && global_irq_enable_i
      && state_ff.status_ctrl[`ACC_BIT_IRQ_EN]))
      else $error("request without all enables");
   // Result follows a raw input held high for three cycles.
   result_sync_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (comparator_raw_i [*3]) |-> result_sync)
      else $error("result did not follow input");
   // Mux path only while converter is off.
   mux_neg_a: assert property (@(posedge clk_i) disable iff (rst_i)
      negative_from_mux_o |-> !converter_enable_i)
      else $error("mux used while converter on");
   // Disabled negative pin reads back zero.
   pin_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(state_ff.pin_disable[1]) |-> !negative_pin_readback_o)
      else $error("disabled pin read nonzero");
   // Capture output is silent when routing is off.
   capture_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !state_ff.status_ctrl[`ACC_BIT_CAPTURE] |-> !capture_trigger_o)
      else $error("capture trigger without routing");
   // Writing disable bit powers comparator off next cycle.
   power_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && wb_adr_i == `ACC_OFF_STATUS_CTRL && wbyte[7]) |=> comparator_power_down_o)
      else $error("disable write ignored");
   // Writing the disable bit as zero powers the comparator on next cycle.
   power_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && wb_adr_i == `ACC_OFF_STATUS_CTRL && !wbyte[`ACC_BIT_DISABLE])
      |=> !comparator_power_down_o)
      else $error("enable write ignored");
   // Disabled positive pin reads back zero.
   pos_readback_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(state_ff.pin_disable[`ACC_BIT_POS_PIN_DIS]) |-> !positive_pin_readback_o)
      else $error("disabled positive pin read nonzero");
   // Writing one to the flag clears it unless a new event arrives.
   flag_w1c_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && wb_adr_i == `ACC_OFF_STATUS_CTRL && wbyte[`ACC_BIT_FLAG] && !mode_event)
      |=> !state_ff.status_ctrl[`ACC_BIT_FLAG])
      else $error("write one did not clear flag");
   // Bandgap steering follows the written bit.
   bandgap_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && wb_adr_i == `ACC_OFF_STATUS_CTRL)
      |=> positive_bandgap_sel_o == $past(wbyte[`ACC_BIT_BANDGAP]))
      else $error("bandgap select did not follow write");
   // Unused pin disable bits read as zero.
   pin_upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (access && wb_adr_i == `ACC_OFF_PIN_DISABLE) |=> wb_dat_o[7:2] == 6'h00)
      else $error("unused pin disable bits read nonzero");
   // Flag follows a falling edge in falling mode within one cycle.
   fall_sets_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode == ACC_MODE_FALL && edge_fall) |=> state_ff.status_ctrl[`ACC_BIT_FLAG])
      else $error("falling edge did not set flag");
   // Flag follows either edge in toggle mode within one cycle.
   toggle_sets_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode == ACC_MODE_TOGGLE && (edge_rise || edge_fall))
      |=> state_ff.status_ctrl[`ACC_BIT_FLAG])
      else $error("toggle did not set flag");
   // A rising edge is a change of the synchronised result since the last cycle.
   edge_from_past_a: assert property (@(posedge clk_i) disable iff (rst_i)
      edge_rise |-> (result_sync && !$past(result_sync)))
      else $error("rising edge without result change");
   // Flag, enable and global enable together raise the request.
   irq_raise_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_ff.status_ctrl[`ACC_BIT_FLAG] && state_ff.status_ctrl[`ACC_BIT_IRQ_EN]
      && global_irq_enable_i) |-> comparator_irq_o)
      else $error("request missing with all enables");
   // Read data carries the synchronised result taken with the request.
   result_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (access && wb_adr_i == `ACC_OFF_STATUS_CTRL)
      |=> wb_dat_o[`ACC_BIT_RESULT] == $past(result_sync))
      else $error("result bit not read back");
   // Setting the mux enable with the converter off selects the mux path.
   mux_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr_en && wb_adr_i == `ACC_OFF_CONV_CTRL_B && wbyte[`ACC_BIT_MUX_EN])
      |=> (negative_from_mux_o || converter_enable_i))
      else $error("mux path not selected");
endmodule // acc_ctrl

//--- testbench/test_acc_ctrl.sv
// Self-checking testbench of the analog comparator control block.
`timescale 1ns/100ps
module test_acc_ctrl;
   import acc_pkg::*;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, comparator_raw_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, checks, miscompares, seed;
   logic converter_enable_i, global_irq_enable_i, irq_vector_ack_i;
   logic negative_pin_digital_i, positive_pin_digital_i, comparator_power_down_o;
   logic positive_bandgap_sel_o, negative_from_mux_o, comparator_irq_o, capture_trigger_o;
   logic capture_routing_enable_o, negative_pin_buffer_off_o, positive_pin_buffer_off_o;
   logic negative_pin_readback_o, positive_pin_readback_o, event_irq_o;
   logic [2:0] channel_select_i, negative_channel_o, converter_trigger_select_o;
   logic [31:0] expq[$];
   logic [1:0] md[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
   logic fr[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   logic ff[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
   logic [7:0] rr[6] = '{8'h50, 8'h7B, 8'h7F, 8'h80, 8'h84, 8'h10};

   acc_ctrl acc_ctrl_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .comparator_raw_i, .comparator_power_down_o,
      .positive_bandgap_sel_o, .negative_from_mux_o, .negative_channel_o, .converter_enable_i,
      .channel_select_i, .global_irq_enable_i, .irq_vector_ack_i, .comparator_irq_o,
      .capture_trigger_o, .capture_routing_enable_o, .converter_trigger_select_o,
      .negative_pin_buffer_off_o, .positive_pin_buffer_off_o, .negative_pin_digital_i,
      .positive_pin_digital_i, .negative_pin_readback_o, .positive_pin_readback_o, .event_irq_o);

   // Free-running 40 MHz clock.
   initial
   begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Compares one value and reports a difference at once.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One classic Wishbone cycle, held until ack is sampled high.
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         miscompares++;
         summarize();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hF);
   endtask

   // A read notes its expected data for the watcher below.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // Takes the oldest note whenever read data is acknowledged.
   always @(posedge clk_i)
   begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
         check(wb_dat_o, (expq.size() > 0) ? expq.pop_front() : 32'hFFFFFFFF);
   end

   // Main sequence.
   initial
   begin
      {checks, miscompares, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
      {comparator_raw_i, converter_enable_i, channel_select_i, irq_vector_ack_i} = '0;
      global_irq_enable_i = 1'b0;
      {negative_pin_digital_i, positive_pin_digital_i} = 2'h3;
      seed = 32'hC9DAD3EB;
      rst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rr[i]) rd(rr[i], 32'h0);
      $display("test reset done");
      wr(8'h7B, 32'hFFFFFFFF);
      wr(8'h7F, 32'hFF);
      rd(8'h7B, 32'h47);
      rd(8'h7F, 32'h03);
      repeat (4) @(posedge clk_i);
      check({converter_trigger_select_o, negative_pin_buffer_off_o, positive_pin_buffer_off_o,
         negative_pin_readback_o, positive_pin_readback_o}, 32'h7C);
      // Random converter state steers the mux; mux enable stays set here.
      for (int i = 0; i < 8; i++)
      begin
         seed = xs(seed);
         converter_enable_i <= seed[3];
         channel_select_i <= seed[2:0];
         @(posedge clk_i);
         check({negative_from_mux_o, negative_channel_o}, {~seed[3], seed[2:0]});
      end
      wr(8'h7B, 32'h0);
      wr(8'h7F, 32'h0);
      repeat (4) @(posedge clk_i);
      check({negative_from_mux_o, negative_pin_readback_o, positive_pin_readback_o}, 3);
      $display("test registers done");
      for (int m = 0; m < 4; m++)
      begin
         wr(8'h50, {30'h0, md[m]});
         wr(8'h50, {27'h1, 2'h0, md[m]});
         comparator_raw_i <= 1'b1;
         repeat (5) @(posedge clk_i);
         rd(8'h50, {26'h0, 1'b1, fr[m], 2'h0, md[m]});
         wr(8'h50, {27'h1, 2'h0, md[m]});
         comparator_raw_i <= 1'b0;
         repeat (5) @(posedge clk_i);
         rd(8'h50, {26'h0, 1'b0, ff[m], 2'h0, md[m]});
      end
      rd(8'h80, 32'h3);
      wr(8'h84, 32'h1);
      @(posedge clk_i);
      check(32'(event_irq_o), 1);
      wr(8'h80, 32'h3);
      @(posedge clk_i);
      check(32'(event_irq_o), 0);
      $display("test modes done");
      wr(8'h50, 32'h3);
      wr(8'h50, 32'h13);
      comparator_raw_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      wr(8'h50, 32'h0B);
      global_irq_enable_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      check(32'(comparator_irq_o), 1);
      global_irq_enable_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check(32'(comparator_irq_o), 0);
      global_irq_enable_i <= 1'b1;
      irq_vector_ack_i <= 1'b1;
      @(posedge clk_i);
      irq_vector_ack_i <= 1'b0;
      @(posedge clk_i);
      check(32'(comparator_irq_o), 0);
      rd(8'h50, 32'h2B);
      $display("test interrupt done");
      wr(8'h50, 32'h3);
      wr(8'h50, 32'hC4);
      bus(1'b1, 8'h50, 32'h0, 4'hE);
      rd(8'h50, 32'hE4);
      // The raw input is still high here, so the routed capture trigger reads one.
      check({comparator_power_down_o, positive_bandgap_sel_o, capture_routing_enable_o,
         capture_trigger_o}, 32'hF);
      wr(8'h50, 32'h0);
      @(posedge clk_i);
      check({comparator_power_down_o, positive_bandgap_sel_o, capture_trigger_o}, 0);
      $display("test control bits done");
      repeat (3) @(posedge clk_i);
      summarize();
   end
endmodule // test_acc_ctrl
